// ### hdl/fcr_params.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the flash controller register block and its command decoder
`ifndef FCR_PARAMS_SVH
`define FCR_PARAMS_SVH

`define FCR_OFS_MODE      8'h00
`define FCR_OFS_COMMAND   8'h04
`define FCR_OFS_STATUS    8'h08
`define FCR_OFS_RESULT    8'h0C

`define FCR_MODE_RESET    32'h0400_0000
`define FCR_STATUS_RESET  32'h0000_0001
`define FCR_MODE_MASK     32'h0501_0F01

`define FCR_MODE_READY_IE 0
`define FCR_MODE_WAIT_LSB 8
`define FCR_MODE_SEQ_CODE_OPT_DISABLE     16
`define FCR_MODE_WIDTH    24
`define FCR_MODE_LOOP     26

`define FCR_KEY_VALUE     8'h5A
`define FCR_CMD_LAST      8'h15

// core busy time of a command, in clock cycles at 10 MHz
`define FCR_OP_TIME_NS    1000
`define FCR_CLK_PERIOD_NS 100
`define FCR_OP_CYCLES     (`FCR_OP_TIME_NS / `FCR_CLK_PERIOD_NS)
// words a multiword result holds before extra reads return zero
`define FCR_RESULT_WORDS  2

`endif

// ### hdl/fcr_pkg.sv
// types shared by the flash controller register block
// assumes fcr_params.svh for the numeric constants
package fcr_pkg;

    typedef enum logic [7:0] {
        FCR_GET_FLASH_INFO    = 8'h00,
        FCR_WRITE_PAGE        = 8'h01,
        FCR_WRITE_PAGE_LOCK   = 8'h02,
        FCR_WIPE_WRITE_PAGE   = 8'h03,
        FCR_WIPE_WRITE_LOCK   = 8'h04,
        FCR_WIPE_ALL          = 8'h05,
        FCR_WIPE_PAGE_GROUP   = 8'h07,
        FCR_SET_LOCK_BIT      = 8'h08,
        FCR_UNLOCK_BIT        = 8'h09,
        FCR_GET_LOCK_BIT      = 8'h0A,
        FCR_SET_NVM_BIT       = 8'h0B,
        FCR_UNSET_NVM_BIT     = 8'h0C,
        FCR_GET_NVM_BIT       = 8'h0D,
        FCR_START_UID_VIEW    = 8'h0E,
        FCR_STOP_UID_VIEW     = 8'h0F,
        FCR_GET_TRIM_BITS     = 8'h10,
        FCR_WIPE_SECTOR       = 8'h11,
        FCR_WRITE_USER_SIG    = 8'h12,
        FCR_WIPE_USER_SIG     = 8'h13,
        FCR_START_SIG_VIEW    = 8'h14,
        FCR_STOP_SIG_VIEW     = 8'h15
    } fcr_cmd_t;

    typedef struct packed {
        logic [7:0]  write_key;
        logic [15:0] command_argument;
        logic [7:0]  command_code;
    } fcr_command_t;

    // decoded command passed to the sequencer
    typedef struct packed {
        logic        start;
        logic [7:0]  code;
        logic [15:0] page;
        logic [5:0]  group_pages;
    } fcr_op_t;

endpackage

// ### hdl/fcr_decode.sv
// command decoder: checks key and code, splits the argument by command
// assumes a single-cycle write strobe qualified by the caller
`timescale 1ns/1ns
`default_nettype none
`include "fcr_params.svh"

module fcr_decode
    import fcr_pkg::*;
(
    // command word
    input  wire logic         cmd_wr,
    input  wire fcr_command_t cmd,
    // result
    output fcr_op_t           op,
    output logic              bad
);

    logic key_ok;
    logic code_ok;

    always_comb begin
        key_ok = (cmd.write_key == `FCR_KEY_VALUE);
        // 0x06 and codes past the last one are invalid
        code_ok = (cmd.command_code <= `FCR_CMD_LAST) && (cmd.command_code != 8'h06);
        op = '0;
        op.code = cmd.command_code;
        op.start = cmd_wr && key_ok && code_ok;
        bad = cmd_wr && !(key_ok && code_ok);
        case (cmd.command_code)
            FCR_WRITE_PAGE, FCR_WRITE_PAGE_LOCK,
            FCR_WIPE_WRITE_PAGE, FCR_WIPE_WRITE_LOCK: begin
                op.page = cmd.command_argument;
            end
            FCR_WIPE_SECTOR, FCR_SET_LOCK_BIT, FCR_UNLOCK_BIT,
            FCR_SET_NVM_BIT, FCR_UNSET_NVM_BIT: begin
                op.page = cmd.command_argument;
            end
            FCR_WIPE_PAGE_GROUP: begin
                // size in [1:0], start page in [15:2] scaled back by four
                op.page = {cmd.command_argument[15:2], 2'b00};
                case (cmd.command_argument[1:0])
                    2'd0: op.group_pages = 6'd4;
                    2'd1: op.group_pages = 6'd8;
                    2'd2: op.group_pages = 6'd16;
                    default: op.group_pages = 6'd32;
                endcase
            end
            default: begin
                op.page = '0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### hdl/fcr_regs.sv
// register file and command sequencer of the embedded flash controller
// assumes a plain strobe bus: read data valid one cycle after the read strobe
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "fcr_params.svh"

// Behaviour
// - mode register at 0x00 resets to 0x0400_0000; command register at 0x04
// - status at 0x08 reads only, resets to 1 meaning ready
// - result at 0x0C reads only, resets to zero; 0x10 to 0xE4 reserved
// - mode bit 0 enables the ready interrupt when controller turns ready
// - mode bits 11:8 give access cycles minus one; accesses stretched
// - mode bit 16 set disables sequential code optimisation
// - mode bit 24 picks 128-bit reads at 0, 64-bit at 1
// - mode bit 26 set enables loop optimisation
// - command word: key 31:24, argument 23:8, code 7:0
// - codes 0x01 to 0x04 program a page given by the argument
// - 0x05 wipes all, 0x11 wipes the sector holding the argument page
// - 0x07 wipes a page group; size in bits 1:0, start in 15:2
// - 0x08 sets, 0x09 clears, 0x0A reads lock bits
// - 0x0B sets, 0x0C clears, 0x0D reads general nvm bits
// - identifier and user signature view, write and wipe codes decoded
// - command acts only when key equals 0x5A
// - error flag set by bad key or code, cleared by status read or command
// - ready bit falls while busy and rises when a command can start
// - wide results come out one word per successive result read
module fcr_regs
    import fcr_pkg::*;
#(
    parameter int OP_CYCLES = `FCR_OP_CYCLES
)(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // register bus
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // flash array side
    input  wire logic        FLASH_ACCESS,
    input  wire logic [63:0] RESULT_DATA,
    input  wire logic        VERIFY_FAIL,
    input  wire logic        LOCKED_HIT,
    output logic             ACCESS_DONE,
    output logic             READ_WIDE,
    output logic             SEQ_OPT_ON,
    output logic             LOOP_OPT_ON,
    output logic             OP_START,
    output logic      [7:0]  OP_CODE,
    output logic      [15:0] OP_PAGE,
    output logic      [5:0]  OP_GROUP,
    output logic             READY_IRQ
);

    logic [31:0]  mode_ff;
    logic         ready_ff;
    logic         cmd_err_ff;
    logic         lock_err_ff;
    logic         flash_err_ff;
    logic [31:0]  busy_cnt_ff;
    logic [63:0]  result_ff;
    logic [1:0]   result_idx_ff;
    logic [3:0]   wait_cnt_ff;
    logic         access_ff;
    logic [31:0]  rdata_ff;
    logic         irq_ff;
    logic         op_start_ff;
    logic [7:0]   op_code_ff;
    logic [15:0]  op_page_ff;
    logic [5:0]   op_group_ff;
    logic         cmd_wr;
    logic         stat_rd;
    logic         res_rd;
    logic         op_go;
    logic         last_cycle;
    fcr_op_t      op;
    logic         bad;
    logic [31:0]  nxt_rdata;
    logic         op_wants_result;

    assign cmd_wr  = WR && (ADDR == `FCR_OFS_COMMAND);
    assign stat_rd = RD && (ADDR == `FCR_OFS_STATUS);
    assign res_rd  = RD && (ADDR == `FCR_OFS_RESULT);

    fcr_decode u_decode (
        .cmd    (fcr_command_t'(WDATA)),
        .cmd_wr (cmd_wr),
        .op     (op),
        .bad    (bad)
    );

    // commands written while busy are dropped; software waits for ready
    assign op_go = op.start && ready_ff;
    assign last_cycle = !ready_ff && (busy_cnt_ff == 32'd1);
    assign op_wants_result = (op_code_ff == FCR_GET_FLASH_INFO) ||
        (op_code_ff == FCR_GET_LOCK_BIT) || (op_code_ff == FCR_GET_NVM_BIT) ||
        (op_code_ff == FCR_GET_TRIM_BITS);

    // mode register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_ff <= `FCR_MODE_RESET;
        end else if (WR && ADDR == `FCR_OFS_MODE) begin
            mode_ff <= WDATA & `FCR_MODE_MASK;
        end
    end

    // ready and busy sequencing
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ready_ff    <= 1'b1;
            busy_cnt_ff <= 32'd0;
        end else if (op_go) begin
            ready_ff    <= 1'b0;
            busy_cnt_ff <= 32'(OP_CYCLES);
        end else if (!ready_ff) begin
            busy_cnt_ff <= busy_cnt_ff - 32'd1;
            if (last_cycle) begin
                ready_ff <= 1'b1;
            end
        end
    end

    // ready interrupt: one pulse when busy ends and enable is set
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= last_cycle && mode_ff[`FCR_MODE_READY_IE];
        end
    end

    // command error: a new bad write wins over the clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cmd_err_ff <= 1'b0;
        end else if (bad) begin
            cmd_err_ff <= 1'b1;
        end else if (stat_rd || cmd_wr) begin
            cmd_err_ff <= 1'b0;
        end
    end

    // lock and verify errors from the array
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            lock_err_ff  <= 1'b0;
            flash_err_ff <= 1'b0;
        end else begin
            if (!ready_ff && LOCKED_HIT) begin
                lock_err_ff <= 1'b1;
            end else if (stat_rd || cmd_wr) begin
                lock_err_ff <= 1'b0;
            end
            if (last_cycle && VERIFY_FAIL) begin
                flash_err_ff <= 1'b1;
            end else if (op_go) begin
                flash_err_ff <= 1'b0;
            end
        end
    end

    // result words: captured at end of a query, stepped by each read until both words are read
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            result_ff     <= 64'h0;
            result_idx_ff <= 2'd0;
        end else if (last_cycle) begin
            result_ff     <= op_wants_result ? RESULT_DATA : 64'h0;
            result_idx_ff <= 2'd0;
        end else if (res_rd && result_idx_ff < 2'(`FCR_RESULT_WORDS)) begin
            result_idx_ff <= result_idx_ff + 2'd1;
        end
    end

    // flash access stretching by wait count
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_cnt_ff <= 4'h0;
            access_ff   <= 1'b0;
        end else if (FLASH_ACCESS && !access_ff) begin
            wait_cnt_ff <= mode_ff[`FCR_MODE_WAIT_LSB +: 4];
            access_ff   <= 1'b1;
        end else if (access_ff) begin
            if (wait_cnt_ff == 4'h0) begin
                access_ff <= 1'b0;
            end else begin
                wait_cnt_ff <= wait_cnt_ff - 4'h1;
            end
        end
    end

    // operation handed to the array
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            op_start_ff <= 1'b0;
            op_code_ff  <= 8'h00;
            op_page_ff  <= 16'h0000;
            op_group_ff <= 6'h00;
        end else begin
            op_start_ff <= op_go;
            if (op_go) begin
                op_code_ff  <= op.code;
                op_page_ff  <= op.page;
                op_group_ff <= op.group_pages;
            end
        end
    end

    // read mux; command and reserved offsets read zero
    always_comb begin
        nxt_rdata = 32'h0;
        case (ADDR)
            `FCR_OFS_MODE:   nxt_rdata = mode_ff;
            `FCR_OFS_STATUS: nxt_rdata = {28'h0, flash_err_ff, lock_err_ff,
                                          cmd_err_ff, ready_ff};
            `FCR_OFS_RESULT: begin
                case (result_idx_ff)
                    2'd0:    nxt_rdata = result_ff[31:0];
                    2'd1:    nxt_rdata = result_ff[63:32];
                    default: nxt_rdata = 32'h0;
                endcase
            end
            default:         nxt_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= RD ? nxt_rdata : 32'h0;
        end
    end

    // mode outputs registered so they come straight from flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            READ_WIDE   <= 1'b1;
            SEQ_OPT_ON  <= 1'b1;
            LOOP_OPT_ON <= 1'b1;
        end else begin
            READ_WIDE   <= !mode_ff[`FCR_MODE_WIDTH];
            SEQ_OPT_ON  <= !mode_ff[`FCR_MODE_SEQ_CODE_OPT_DISABLE];
            LOOP_OPT_ON <= mode_ff[`FCR_MODE_LOOP];
        end
    end

    assign RDATA       = rdata_ff;
    assign ACCESS_DONE = access_ff;
    assign OP_START    = op_start_ff;
    assign OP_CODE     = op_code_ff;
    assign OP_PAGE     = op_page_ff;
    assign OP_GROUP    = op_group_ff;
    assign READY_IRQ   = irq_ff;

endmodule
`default_nettype wire

// ### bench/fcr_regs_properties.sv
// concurrent checks on the ports of the flash controller register block
// assumes OP_CYCLES of at least 3 and one clock domain
`timescale 1ns/1ns
`default_nettype none
module fcr_regs_properties (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESETN,
    // register bus
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // sequencer side
    input wire logic        READ_WIDE,
    input wire logic        SEQ_OPT_ON,
    input wire logic        LOOP_OPT_ON,
    input wire logic        OP_START,
    input wire logic [7:0]  OP_CODE,
    input wire logic [15:0] OP_PAGE,
    input wire logic [5:0]  OP_GROUP,
    input wire logic        READY_IRQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    wire logic mode_wr = WR && ADDR == 8'h00;
    wire logic cmd_wr  = WR && ADDR == 8'h04;

    unused_read_a: assert property (
        RD && (ADDR == 8'h04 || ADDR >= 8'h10) |=> RDATA == 32'h0)
        else $error("command or reserved read not zero");
    mode_outputs_a: assert property (
        mode_wr ##1 !mode_wr |=> {READ_WIDE, SEQ_OPT_ON, LOOP_OPT_ON} ==
            {!$past(WDATA[24], 2), !$past(WDATA[16], 2), $past(WDATA[26], 2)})
        else $error("mode controls do not follow the mode write");
    key_gate_a: assert property (
        cmd_wr && WDATA[31:24] != 8'h5A |=> !OP_START)
        else $error("command started with a bad key");
    invalid_code_a: assert property (
        cmd_wr && (WDATA[7:0] == 8'h06 || WDATA[7:0] > 8'h15) |=> !OP_START)
        else $error("invalid command code started");
    op_fields_a: assert property (
        OP_START |-> $past(cmd_wr) && $past(WDATA[31:24]) == 8'h5A &&
            OP_CODE == $past(WDATA[7:0]))
        else $error("start or code does not match the command write");
    page_arg_a: assert property (
        OP_START && OP_CODE inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h11} |->
            OP_PAGE == $past(WDATA[23:8]))
        else $error("page does not match the argument");
    group_arg_a: assert property (
        OP_START && OP_CODE == 8'h07 |-> OP_GROUP == 6'h04 << $past(WDATA[9:8]) &&
            OP_PAGE == {$past(WDATA[23:10]), 2'b00})
        else $error("page group size or start wrong");
    busy_no_irq_a: assert property (
        OP_START |-> !READY_IRQ [*3])
        else $error("ready interrupt while busy");
    irq_pulse_a: assert property (
        READY_IRQ |=> !READY_IRQ)
        else $error("ready interrupt longer than one cycle");
endmodule

bind fcr_regs fcr_regs_properties chk_u (
    .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .READ_WIDE(READ_WIDE), .SEQ_OPT_ON(SEQ_OPT_ON),
    .LOOP_OPT_ON(LOOP_OPT_ON), .OP_START(OP_START), .OP_CODE(OP_CODE),
    .OP_PAGE(OP_PAGE), .OP_GROUP(OP_GROUP), .READY_IRQ(READY_IRQ)
);
`default_nettype wire

// ### bench/fcr_regs_tb.sv
// self-checking bench for the flash controller register block
// assumes the checker binds itself to fcr_regs
`timescale 1ns/1ns
`default_nettype none
module fcr_regs_tb;
    logic        CLK;
    logic        RESETN;
    logic [7:0]  ADDR;
    logic [31:0] WDATA;
    logic        WR;
    logic        RD;
    logic [31:0] RDATA;
    logic [63:0] RESULT_DATA;
    logic        FLASH_ACCESS;
    logic        ACCESS_DONE;
    logic        READ_WIDE;
    logic        SEQ_OPT_ON;
    logic        LOOP_OPT_ON;
    logic        OP_START;
    logic [7:0]  OP_CODE;
    logic [15:0] OP_PAGE;
    logic [5:0]  OP_GROUP;
    logic        READY_IRQ;
    int          tests_run = 0;
    int          fail_count = 0;
    int          irq_n = 0;

    // short busy time keeps the run small while leaving room to see busy
    fcr_regs #(.OP_CYCLES(6)) dut_u (
        .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .FLASH_ACCESS(FLASH_ACCESS), .RESULT_DATA(RESULT_DATA),
        .VERIFY_FAIL(1'b0), .LOCKED_HIT(1'b0), .ACCESS_DONE(ACCESS_DONE),
        .READ_WIDE(READ_WIDE),
        .SEQ_OPT_ON(SEQ_OPT_ON), .LOOP_OPT_ON(LOOP_OPT_ON), .OP_START(OP_START),
        .OP_CODE(OP_CODE), .OP_PAGE(OP_PAGE), .OP_GROUP(OP_GROUP), .READY_IRQ(READY_IRQ)
    );

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        if (READY_IRQ === 1'b1)
            irq_n++;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    function automatic logic [15:0] exp_page(input logic [7:0] c, input logic [15:0] a);
        return (c == 8'h07) ? {a[15:2], 2'b00} : a;
    endfunction

    // accepted command: start pulse, fields, busy status, then wait for ready
    task automatic cmd(input logic [7:0] c, input logic [15:0] a);
        logic [31:0] s;
        wr(8'h04, {8'h5A, a, c});
        chk("start", 32'h1, {31'h0, OP_START});
        chk("code", {24'h0, c}, {24'h0, OP_CODE});
        if (c inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h11})
            chk("page", {16'h0, exp_page(c, a)}, {16'h0, OP_PAGE});
        if (c == 8'h07)
            chk("group", {26'h0, 6'h04 << a[1:0]}, {26'h0, OP_GROUP});
        rd(8'h08, s);
        chk("busy status", 32'h0, s);
        s = 32'h0;
        for (int i = 0; i < 20 && s[0] !== 1'b1; i++)
            rd(8'h08, s);
        if (s[0] !== 1'b1) begin
            fail_count++;
            $display("wrong value ready expected 1 seen 0");
            tally_and_finish();
        end
    endtask

    initial begin
        logic [31:0] v;
        logic [31:0] r;
        logic [63:0] rv;
        logic [15:0] a;
        logic [3:0]  k;
        logic [7:0]  q [4] = '{8'h00, 8'h0A, 8'h0D, 8'h10};
        logic [31:0] bad [4] = '{32'hA500_0001, 32'h5A00_0006, 32'h5A00_0016, 32'h5A00_00FF};
        int n;
        RESETN = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0;
        WR = 1'b0;
        RD = 1'b0;
        RESULT_DATA = 64'h0;
        FLASH_ACCESS = 1'b0;
        void'($urandom(32'h44BA135F));
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        rd(8'h00, r);
        chk("mode reset", 32'h0400_0000, r);
        rd(8'h08, r);
        chk("status reset", 32'h0000_0001, r);
        rd(8'h0C, r);
        chk("result reset", 32'h0, r);
        $display("test reset values done");
        for (n = 0; n < 6; n++) begin
            v = (n == 0) ? 32'hFFFF_FFFF : (n == 1) ? 32'h0 : $urandom;
            wr(8'h00, v);
            rd(8'h00, r);
            chk("mode", v & 32'h0501_0F01, r);
            r = {29'h0, READ_WIDE, SEQ_OPT_ON, LOOP_OPT_ON};
            chk("mode outputs", {29'h0, ~v[24], ~v[16], v[26]}, r);
        end
        $display("test mode register done");
        for (n = 0; n < 4; n++) begin
            k = (n == 0) ? 4'h0 : (n == 1) ? 4'hF : 4'($urandom);
            wr(8'h00, {20'h0, k, 8'h00});
            // access requested only once the mode write has settled
            @(posedge CLK);
            FLASH_ACCESS <= 1'b1;
            @(posedge CLK);
            FLASH_ACCESS <= 1'b0;
            r = 32'h0;
            for (int i = 0; i < 40; i++) begin
                #1;
                if (ACCESS_DONE === 1'b1)
                    r++;
                @(posedge CLK);
            end
            chk("access cycles", {28'h0, k} + 32'h1, r);
        end
        $display("test wait states done");
        wr(8'h00, 32'h0400_0000);
        wr(8'h10, 32'hFFFF_FFFF);
        wr(8'hE4, 32'hFFFF_FFFF);
        rd(8'h10, r);
        chk("reserved read", 32'h0, r);
        rd(8'h04, r);
        chk("command read", 32'h0, r);
        rd(8'h00, r);
        chk("mode kept", 32'h0400_0000, r);
        $display("test reserved space done");
        n = irq_n;
        cmd(8'h01, 16'h0123);
        repeat (3) @(posedge CLK);
        chk("masked irq", n, irq_n);
        wr(8'h00, 32'h0400_0001);
        n = irq_n;
        for (int c = 0; c < 22; c++) begin
            a = (c inside {1, 2, 3, 4, 8, 9, 11, 12, 17}) ? 16'($urandom) : 16'h0;
            if (c != 6)
                cmd(8'(c), a);
        end
        repeat (3) @(posedge CLK);
        chk("irq count", n + 21, irq_n);
        $display("test command codes done");
        for (int s = 0; s < 4; s++)
            cmd(8'h07, (16'($urandom) << (s + 2)) | 16'(s));
        $display("test page groups done");
        for (n = 0; n < 4; n++) begin
            rv = {$urandom, $urandom};
            @(posedge CLK);
            RESULT_DATA <= rv;
            cmd(q[n], 16'h0);
            rd(8'h0C, r);
            chk("result low", rv[31:0], r);
            rd(8'h0C, r);
            chk("result high", rv[63:32], r);
            rd(8'h0C, r);
            chk("result extra", 32'h0, r);
        end
        $display("test results done");
        for (n = 0; n < 4; n++) begin
            wr(8'h04, bad[n]);
            chk("refused start", 32'h0, {31'h0, OP_START});
            rd(8'h08, r);
            chk("error set", 32'h3, r);
            rd(8'h08, r);
            chk("error cleared", 32'h1, r);
        end
        wr(8'h04, bad[0]);
        cmd(8'h0F, 16'h0);
        $display("test refused commands done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
